/* File: design/ms_red_params.svh */
// Constants of the master/slave redundancy controller: offsets, bits, resets.
// Assumes inclusion by bare name from every design file that needs them.
//
// Notes on behaviour
// - Slave mode forces cross-connect input priority on the primary path to one.
// - Slave mode forces phase build-out off whatever software programmed.
// - Slave mode forces revertive reference selection on for the primary path.
// - Slave mode forces the primary DPLL onto its acquisition bandwidth.
// - Master mode uses programmed cross-connect priority; zero disables that input.
// - Master mode follows registers; automatic bandwidth picks locked or acquisition.
// - Every pin-forced function is also a register setting used when not forced.
// - Inputs marked invalid in the remote mask are invalid locally too.
// - Primary and secondary paths keep separate input priority tables.
// - A priority of zero disables the input on that path.
// - Locked with build-out off, outputs at reference rate are in phase.
// - Lower primary rates are divisions of the locked reference rate.
// - Secondary outputs keep fixed phase to the secondary selected input.
// - Locked to multiframe sync with build-out off aligns all; frame sync aligns all but multiframe.
// - Table-select bit lets secondary table choose the secondary phase detector input.
// - With build-out off the programmed output phase offset is applied.
// - Build-out dropped while locked makes the DPLL pull back to zero error.
`ifndef MS_RED_PARAMS_SVH
`define MS_RED_PARAMS_SVH

`define NUM_INPUTS      14
`define ADDR_W          6
`define DATA_W          8
`define PRIO_W          4
`define IDX_W           4
`define TBL_AW          5

// Address map
`define TBL_REGION_BIT  5
`define TBL_PATH_BIT    4
`define REG_CTRL        6'h20
`define REG_SEC_CTRL    6'h21
`define REG_RVAL_LO     6'h22
`define REG_RVAL_HI     6'h23
`define REG_LVAL_LO     6'h24
`define REG_LVAL_HI     6'h25
`define REG_PH_OFF      6'h26
`define REG_STATUS      6'h27
`define REG_PRI_SEL     6'h28
`define REG_SEC_SEL     6'h29

// Field positions
`define CTRL_PBO        0
`define CTRL_REV        1
`define CTRL_AUTO_BW    2
`define CTRL_MAN_ACQ    3
`define SEC_TBL_SEL     4
`define SEC_FORCE_MSB   3

// Reset values
`define CTRL_RST        8'h05
`define SEC_CTRL_RST    8'h00
`define RVAL_RST        16'hFFFF
`define PH_OFF_RST      8'h00
`define RD_IDLE         8'h00

// Selection constants
`define XC_INPUT        4'hA
`define XC_SLAVE_PRIO   4'h1
`define PRIO_OFF        4'h0
`define NO_SEL          4'hF
`define REF_FRAME       2'h1
`define REF_MFRAME      2'h2

`endif

/* File: design/ms_red_pkg.sv */
// Types shared by the redundancy controller and its priority table.
// Assumes the constants header is available on the include path.
package ms_red_pkg;
	typedef logic [3:0] prio_t;
	typedef logic [3:0] idx_t;
	typedef enum logic [1:0] {ALIGN_NONE, ALIGN_BUT_MF, ALIGN_ALL} sync_align_t;
endpackage

/* File: design/prio_mem_if.sv */
// Carrier between the selection logic and the priority table memory.
// Assumes one clock domain; the controller owns the write and read addresses.
`timescale 1ns/1ps
`default_nettype none
interface prio_mem_if #(parameter int AW = 5, parameter int W = 4);
	logic          we;
	logic [AW-1:0] waddr;
	logic [W-1:0]  wdata;
	logic [AW-1:0] raddr;
	logic [W-1:0]  rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: design/prio_table_mem.sv */
// Priority table memory: one write port, one read port, registered read data.
// Assumes the controller keeps addresses in range; reset clears every entry.
`timescale 1ns/1ps
`default_nettype none
module prio_table_mem #(
	parameter int AW = 5,
	parameter int W  = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Table port
	prio_mem_if.mem  port
);
	logic [W-1:0] mem_r [2**AW];
	logic [W-1:0] rdata_r;

	// A table needs at least one address bit and one data bit
	if (AW < 1 || W < 1)
	begin : g_bad_geom
		$error("table geometry must have AW and W of at least one");
	end

	// Cleared to zero so every input starts disabled until programmed
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < 2**AW; i++)
				mem_r[i] <= '0;
		end
		else if (port.we)
			mem_r[port.waddr] <= port.wdata;
	end

	// Read data come out of a register, one cycle after the address
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rdata_r <= '0;
		else
			rdata_r <= mem_r[port.raddr];
	end

	assign port.rdata = rdata_r;
endmodule // prio_table_mem
`default_nettype wire

/* File: design/master_slave_redundancy_ctrl.sv */
// Master/slave redundancy control: pin overrides, priority scan, validity merge.
// Assumes the register port master of the house bus and status from DPLLs.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ms_red_params.svh"
module master_slave_redundancy_ctrl #(
	parameter int NIN = `NUM_INPUTS
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	// Redundancy select pin, high means master
	input  wire logic                    master_slave_select,
	// Register port
	input  wire logic [`ADDR_W-1:0]      addr,
	input  wire logic [`DATA_W-1:0]      wr_data,
	input  wire logic                    wr_en,
	input  wire logic                    rd_en,
	output logic      [`DATA_W-1:0]      rd_data,
	// Reference state from monitors and DPLLs
	input  wire logic [NIN-1:0]          local_valid,
	input  wire logic                    primary_locked,
	input  wire logic                    secondary_locked,
	input  wire logic [1:0]              ref_kind,
	// Effective settings
	output logic                         pbo_active,
	output logic                         revertive_active,
	output logic                         acq_bw_active,
	output logic                         pbo_realign,
	output logic      [`IDX_W-1:0]       primary_sel,
	output logic      [`IDX_W-1:0]       secondary_sel,
	output logic      [`IDX_W-1:0]       secondary_pd_sel,
	output logic      [`DATA_W-1:0]      phase_offset_out,
	output logic                         out_ref_aligned,
	output logic                         secondary_aligned,
	output ms_red_pkg::sync_align_t      sync_align
);
	// ****************************************************************
	// Checks and declarations
	// ****************************************************************
	// The cross-connect input must exist; index 4'hF is kept for no selection
	if (NIN <= int'(`XC_INPUT) || NIN > 15)
	begin : g_bad_nin
		$error("NIN must cover the cross-connect input and stay below 16");
	end

	localparam ms_red_pkg::idx_t LAST = 4'(NIN - 1);

	logic                    ms_s1_r;
	logic                    ms_s2_r;
	logic                    slave;
	logic [`DATA_W-1:0]      ctrl_r;
	logic [`DATA_W-1:0]      sec_ctrl_r;
	logic [15:0]             rval_r;
	logic [`DATA_W-1:0]      ph_off_r;
	logic [NIN-1:0]          eff_valid;
	logic [15:0]             lval16;
	logic                    pbo_eff;
	logic                    rev_eff;
	logic                    acq_eff;
	ms_red_pkg::idx_t        idx_r;
	logic                    path_r;
	logic                    pend_r;
	ms_red_pkg::idx_t        pend_idx_r;
	logic                    pend_path_r;
	logic                    found_r;
	ms_red_pkg::prio_t       best_r;
	ms_red_pkg::idx_t        bidx_r;
	logic                    cur_ok_r;
	ms_red_pkg::prio_t       prio_eff;
	ms_red_pkg::idx_t        cur;
	ms_red_pkg::idx_t        cand_idx;
	ms_red_pkg::idx_t        sel_nxt;
	logic                    usable;
	logic                    better;
	logic                    cur_ok_now;
	logic                    cand_found;
	logic                    rev_path;
	logic                    last;

	prio_mem_if #(.AW(`TBL_AW), .W(`PRIO_W)) mif ();

	prio_table_mem #(.AW(`TBL_AW), .W(`PRIO_W)) u_tbl (
		.clk     (clk),
		.sys_rst (sys_rst),
		.port    (mif)
	);

	// ****************************************************************
	// Select pin synchroniser
	// ****************************************************************
	// Two stages; only the second one is looked at by the logic
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ms_s1_r <= 1'b1;
			ms_s2_r <= 1'b1;
		end
		else
		begin
			ms_s1_r <= master_slave_select;
			ms_s2_r <= ms_s1_r;
		end
	end

	assign slave = ~ms_s2_r;

	// ****************************************************************
	// Register file
	// ****************************************************************
	// Software settings stay in force whenever the pin does not override
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctrl_r     <= `CTRL_RST;
			sec_ctrl_r <= `SEC_CTRL_RST;
			rval_r     <= `RVAL_RST;
			ph_off_r   <= `PH_OFF_RST;
		end
		else if (wr_en)
		begin
			case (addr)
				`REG_CTRL:     ctrl_r <= wr_data;
				`REG_SEC_CTRL: sec_ctrl_r <= wr_data;
				`REG_RVAL_LO:  rval_r[7:0] <= wr_data;
				`REG_RVAL_HI:  rval_r[15:8] <= wr_data;
				`REG_PH_OFF:   ph_off_r <= wr_data;
				default:       ;
			endcase
		end
	end

	// Table writes: one word per input, path chosen by one address bit
	assign mif.we    = wr_en && !addr[`TBL_REGION_BIT] && (addr[3:0] <= LAST);
	assign mif.waddr = addr[`TBL_AW-1:0];
	assign mif.wdata = wr_data[`PRIO_W-1:0];

	assign lval16 = 16'(local_valid);

	// Read data stand only in the cycle after the strobe; tables read as zero
	always_ff @(posedge clk)
	begin
		if (sys_rst || !rd_en)
			rd_data <= `RD_IDLE;
		else
		begin
			case (addr)
				`REG_CTRL:     rd_data <= ctrl_r;
				`REG_SEC_CTRL: rd_data <= sec_ctrl_r;
				`REG_RVAL_LO:  rd_data <= rval_r[7:0];
				`REG_RVAL_HI:  rd_data <= rval_r[15:8];
				`REG_LVAL_LO:  rd_data <= lval16[7:0];
				`REG_LVAL_HI:  rd_data <= lval16[15:8];
				`REG_PH_OFF:   rd_data <= ph_off_r;
				`REG_STATUS:   rd_data <= {3'h0, primary_locked, acq_bw_active,
					revertive_active, pbo_active, slave};
				`REG_PRI_SEL:  rd_data <= {4'h0, primary_sel};
				`REG_SEC_SEL:  rd_data <= {4'h0, secondary_sel};
				default:       rd_data <= `RD_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Pin overrides
	// ****************************************************************
	// Slave forces build-out off, revertive on and acquisition bandwidth
	assign pbo_eff = ms_s2_r & ctrl_r[`CTRL_PBO];
	assign rev_eff = slave | ctrl_r[`CTRL_REV];
	assign acq_eff = slave | (ctrl_r[`CTRL_AUTO_BW] ? !primary_locked
		: ctrl_r[`CTRL_MAN_ACQ]);

	// Remote mask vetoes what the local monitors accept
	assign eff_valid = local_valid & rval_r[NIN-1:0];

	// ****************************************************************
	// Priority scan
	// ****************************************************************
	// Walks every input of both tables in turn, one entry per cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			idx_r       <= '0;
			path_r      <= 1'b0;
			pend_r      <= 1'b0;
			pend_idx_r  <= '0;
			pend_path_r <= 1'b0;
		end
		else
		begin
			pend_r      <= 1'b1;
			pend_idx_r  <= idx_r;
			pend_path_r <= path_r;
			if (idx_r == LAST)
			begin
				idx_r  <= '0;
				path_r <= ~path_r;
			end
			else
				idx_r <= idx_r + 4'h1;
		end
	end

	assign mif.raddr = {path_r, idx_r};

	// Evaluate the entry whose priority word has just come back
	always_comb
	begin
		if (slave && !pend_path_r && pend_idx_r == `XC_INPUT)
			prio_eff = `XC_SLAVE_PRIO;
		else
			prio_eff = mif.rdata;
		usable     = pend_r && (prio_eff != `PRIO_OFF) && eff_valid[pend_idx_r];
		better     = usable && (!found_r || prio_eff < best_r);
		cur        = pend_path_r ? secondary_sel : primary_sel;
		cur_ok_now = cur_ok_r || (usable && pend_idx_r == cur);
		cand_idx   = better ? pend_idx_r : bidx_r;
		cand_found = found_r || usable;
		rev_path   = pend_path_r ? ctrl_r[`CTRL_REV] : rev_eff;
		last       = pend_r && (pend_idx_r == LAST);
		// Non-revertive keeps a still usable current input
		if (!cand_found)
			sel_nxt = `NO_SEL;
		else if (rev_path || !cur_ok_now)
			sel_nxt = cand_idx;
		else
			sel_nxt = cur;
	end

	// Best candidate of the running pass; cleared at each path boundary
	always_ff @(posedge clk)
	begin
		if (sys_rst || last)
		begin
			found_r  <= 1'b0;
			best_r   <= '0;
			bidx_r   <= '0;
			cur_ok_r <= 1'b0;
		end
		else
		begin
			if (better)
			begin
				found_r <= 1'b1;
				best_r  <= prio_eff;
				bidx_r  <= pend_idx_r;
			end
			cur_ok_r <= cur_ok_now;
		end
	end

	// A selection only moves at the end of a full pass over its table
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			primary_sel   <= `NO_SEL;
			secondary_sel <= `NO_SEL;
		end
		else if (last && pend_path_r)
			secondary_sel <= sel_nxt;
		else if (last)
			primary_sel <= sel_nxt;
	end

	// ****************************************************************
	// Effective outputs
	// ****************************************************************
	// Registered so every output leaves straight from a flip-flop
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pbo_active       <= 1'b1;
			revertive_active <= 1'b0;
			acq_bw_active    <= 1'b1;
			pbo_realign      <= 1'b0;
			phase_offset_out <= `PH_OFF_RST;
			secondary_pd_sel <= '0;
		end
		else
		begin
			pbo_active       <= pbo_eff;
			revertive_active <= rev_eff;
			acq_bw_active    <= acq_eff;
			pbo_realign      <= pbo_active & !pbo_eff & primary_locked;
			phase_offset_out <= pbo_eff ? `PH_OFF_RST : ph_off_r;
			secondary_pd_sel <= sec_ctrl_r[`SEC_TBL_SEL] ? secondary_sel
				: sec_ctrl_r[`SEC_FORCE_MSB:0];
		end
	end

	// Phase relation flags handed to the output dividers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			out_ref_aligned   <= 1'b0;
			secondary_aligned <= 1'b0;
			sync_align        <= ms_red_pkg::ALIGN_NONE;
		end
		else
		begin
			out_ref_aligned   <= primary_locked & !pbo_eff;
			secondary_aligned <= secondary_locked;
			if (!(primary_locked && !pbo_eff))
				sync_align <= ms_red_pkg::ALIGN_NONE;
			else if (ref_kind == `REF_MFRAME)
				sync_align <= ms_red_pkg::ALIGN_ALL;
			else if (ref_kind == `REF_FRAME)
				sync_align <= ms_red_pkg::ALIGN_BUT_MF;
			else
				sync_align <= ms_red_pkg::ALIGN_NONE;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	logic [NIN-1:0] eff_valid_d;
	always_ff @(posedge clk)
	begin
		eff_valid_d <= eff_valid;
	end

	slave_pbo_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		!ms_s2_r |=> !pbo_active) else $error("build-out on in slave mode");
	slave_rev_on_a: assert property (@(posedge clk) disable iff (sys_rst)
		!ms_s2_r |=> revertive_active) else $error("revertive off in slave mode");
	slave_acq_bw_a: assert property (@(posedge clk) disable iff (sys_rst)
		!ms_s2_r |=> acq_bw_active) else $error("slave not on acquisition bandwidth");
	auto_bw_a: assert property (@(posedge clk) disable iff (sys_rst)
		ms_s2_r && ctrl_r[`CTRL_AUTO_BW] && primary_locked |=> !acq_bw_active)
		else $error("auto bandwidth ignored lock");
	pin_apply_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(master_slave_select) ##1 !master_slave_select |-> ##[1:3] !pbo_active)
		else $error("slave pin not applied in time");
	sel_valid_a: assert property (@(posedge clk) disable iff (sys_rst)
		$changed(primary_sel) && primary_sel != `NO_SEL |-> eff_valid_d[primary_sel])
		else $error("invalid input selected");
	offset_apply_a: assert property (@(posedge clk) disable iff (sys_rst)
		!pbo_eff ##1 $stable(ph_off_r) |-> phase_offset_out == ph_off_r)
		else $error("phase offset not applied");
	realign_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(pbo_eff) && primary_locked |=> pbo_realign)
		else $error("no realign after build-out drop");
	pd_forced_a: assert property (@(posedge clk) disable iff (sys_rst)
		!sec_ctrl_r[`SEC_TBL_SEL] |=> secondary_pd_sel == $past(sec_ctrl_r[`SEC_FORCE_MSB:0]))
		else $error("forced phase detector input ignored");
endmodule // master_slave_redundancy_ctrl
`default_nettype wire

/* File: sim/peer_timing_model.sv */
// Model of the peer timing device: keeps its own source-validity view.
// Assumes the bench plays host software and copies that view across.
`timescale 1ns/1ps
`default_nettype none
module peer_timing_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Fault injection from the bench
	input  wire logic        fail_en,
	input  wire logic [3:0]  fail_idx,
	// Local validity as the peer reports it
	output logic      [13:0] peer_valid
);
	// A failed source stays invalid until reset, so the host copy is stable
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			peer_valid <= 14'h3FFF;
		else if (fail_en)
			peer_valid <= peer_valid & ~(14'h0001 << fail_idx);
	end
endmodule // peer_timing_model
`default_nettype wire

/* File: sim/master_slave_redundancy_ctrl_bench.sv */
// Testbench for the redundancy controller and its peer model.
// Assumes the constants header on the include path and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "ms_red_params.svh"
module master_slave_redundancy_ctrl_bench;
	// ****************************************
	// Signals
	// ****************************************
	logic        clk, sys_rst, master_slave_select, wr_en, rd_en, fail_en;
	logic        primary_locked, secondary_locked, pbo_active, revertive_active;
	logic        acq_bw_active, pbo_realign, out_ref_aligned, secondary_aligned;
	logic [5:0]  addr;
	logic [7:0]  wr_data, rd_data, phase_offset_out;
	logic [13:0] local_valid, peer_valid;
	logic [3:0]  primary_sel, secondary_sel, secondary_pd_sel, fail_idx;
	logic [1:0]  ref_kind;
	int          num_errors, checks_done;
	ms_red_pkg::sync_align_t sync_align;

	master_slave_redundancy_ctrl dut (.clk(clk), .sys_rst(sys_rst),
		.master_slave_select(master_slave_select), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .local_valid(local_valid),
		.primary_locked(primary_locked), .secondary_locked(secondary_locked),
		.ref_kind(ref_kind), .pbo_active(pbo_active), .revertive_active(revertive_active),
		.acq_bw_active(acq_bw_active), .pbo_realign(pbo_realign),
		.primary_sel(primary_sel), .secondary_sel(secondary_sel),
		.secondary_pd_sel(secondary_pd_sel), .phase_offset_out(phase_offset_out),
		.out_ref_aligned(out_ref_aligned), .secondary_aligned(secondary_aligned),
		.sync_align(sync_align));

	peer_timing_model peer (.clk(clk), .sys_rst(sys_rst), .fail_en(fail_en),
		.fail_idx(fail_idx), .peer_valid(peer_valid));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe, then returns to zero
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 chk(rd_data, exp);
		cyc(1);
		chk(rd_data, `RD_IDLE);
	endtask

	task automatic set_pin(input logic v);
		@(posedge clk);
		master_slave_select <= v;
		cyc(4);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		chk(pbo_active, 1'b1);
		chk(acq_bw_active, 1'b1);
		chk(primary_sel, `NO_SEL);
		rd(`REG_CTRL, `CTRL_RST);
		rd(`REG_RVAL_HI, 8'hFF);
		rd(6'h3F, `RD_IDLE);
	endtask

	// Slave forces the settings even against a register write
	task automatic t_pin();
		set_pin(1'b0);
		// Host keeps the master on locked bandwidth; the slave runs wider
		wr(`REG_CTRL, 8'h02);
		cyc(3);
		chk({pbo_active, revertive_active, acq_bw_active}, 3'h3);
		rd(`REG_STATUS, 8'h0D);
		set_pin(1'b1);
		chk({pbo_active, revertive_active, acq_bw_active}, 3'h2);
	endtask

	task automatic t_misc();
		int n;
		wr(`REG_CTRL, 8'h05);
		cyc(3);
		chk({pbo_active, acq_bw_active}, 2'h3);
		@(posedge clk);
		primary_locked <= 1'b1;
		cyc(3);
		chk(acq_bw_active, 1'b0);
		wr(`REG_CTRL, 8'h04);
		n = 0;
		repeat (6)
		begin
			@(posedge clk);
			#1 n += (pbo_realign === 1'b1);
		end
		chk(n, 1);
		wr(`REG_PH_OFF, 8'h3C);
		cyc(3);
		chk(phase_offset_out, 8'h3C);
		chk(out_ref_aligned, 1'b1);
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk);
			ref_kind <= k[1:0];
			cyc(3);
			chk(sync_align, (k == `REF_MFRAME) ? ms_red_pkg::ALIGN_ALL :
				(k == `REF_FRAME) ? ms_red_pkg::ALIGN_BUT_MF : ms_red_pkg::ALIGN_NONE);
		end
		@(posedge clk);
		secondary_locked <= 1'b1;
		cyc(3);
		chk(secondary_aligned, 1'b1);
	endtask

	// Separate tables; the cross-connect input is off on the primary path
	task automatic t_select();
		wr(6'h03, 8'h02);
		wr(6'h07, 8'h04);
		wr(6'h0A, 8'h00);
		wr(6'h15, 8'h03);
		wr(6'h1A, 8'h00);
		cyc(64);
		chk(primary_sel, 4'h3);
		chk(secondary_sel, 4'h5);
		set_pin(1'b0);
		cyc(64);
		chk(primary_sel, `XC_INPUT);
		set_pin(1'b1);
		cyc(64);
		chk(primary_sel, 4'h3);
		wr(`REG_SEC_CTRL, 8'h06);
		cyc(3);
		chk(secondary_pd_sel, 4'h6);
		wr(`REG_SEC_CTRL, 8'h10);
		cyc(3);
		chk(secondary_pd_sel, 4'h5);
	endtask

	// Peer loses input 3; host copies the peer view into the remote mask
	task automatic t_remote();
		@(posedge clk);
		fail_idx <= 4'h3;
		fail_en <= 1'b1;
		@(posedge clk);
		fail_en <= 1'b0;
		cyc(1);
		wr(`REG_RVAL_LO, peer_valid[7:0]);
		wr(`REG_RVAL_HI, {2'b00, peer_valid[13:8]});
		cyc(64);
		chk(primary_sel, 4'h7);
		rd(`REG_RVAL_LO, 8'hF7);
		rd(`REG_LVAL_LO, 8'hFF);
		rd(`REG_PRI_SEL, 8'h07);
		rd(`REG_SEC_SEL, 8'h05);
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ****************************************
	// Clock, watchdog and main sequence
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// A hang counts as a mismatch and still reaches the verdict
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("Timeout at %0t", $time);
		summarize();
	end

	// Inputs start idle in master mode with every local source valid
	initial
	begin
		num_errors = 0;
		checks_done = 0;
		sys_rst = 1'b1;
		master_slave_select = 1'b1;
		{addr, wr_data, wr_en, rd_en, fail_en, fail_idx} = '0;
		{primary_locked, secondary_locked, ref_kind} = '0;
		local_valid = 14'h3FFF;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		cyc(1);
		t_reset();
		t_pin();
		t_misc();
		t_select();
		t_remote();
		summarize();
	end
endmodule // master_slave_redundancy_ctrl_bench
`default_nettype wire
